// ==== dv/mtc_host_model.sv ====
// Host model that issues commands on the register bank command port
module mtc_host_model
	import mtc_pkg::*;
(
	input  wire logic        clk,
	output mtc_cmd_s         cmd,
	output logic             cmd_valid,
	input  wire logic        rsp_valid,
	input  wire logic [31:0] rsp_data,
	input  wire logic        cmd_ignored
);
	timeunit 1ns;
	timeprecision 1ps;

	// Port idle from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd       = '0;
	end

	// One command held for a single edge; the answer is taken at the next edge
	task automatic access(input logic w, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ig, output logic ok);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd       <= '{write: w, addr: a, wdata: d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		// Released fields carry garbage rather than the last command
		cmd       <= ~cmd;
		@(posedge clk);
		q  = rsp_data;
		ig = cmd_ignored;
		ok = rsp_valid;
	endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the temperature and result register bank
module tb
	import mtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// One command row: inputs beside the answer they should give
	typedef struct packed {
		logic        w;
		logic [6:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        ig;
	} mtc_row_s;

	localparam mtc_row_s ROWS [14] = '{
		'{1'b0, MTC_SCALE,     32'h0000_0000, 32'h0000_58C1, 1'b0},
		'{1'b1, MTC_SENSOR_T,  32'h0000_1234, 32'h0000_0000, 1'b1},
		'{1'b0, MTC_SENSOR_T,  32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 7'h00,         32'h0000_0000, 32'h0000_0000, 1'b1},
		'{1'b1, MTC_REF_T,     32'h000D_0426, 32'h0000_0000, 1'b0},
		'{1'b0, MTC_REF_T,     32'h0000_0000, 32'h000D_0426, 1'b0},
		'{1'b1, MTC_RTC_CONST, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
		'{1'b0, MTC_RTC_CONST, 32'h0000_0000, 32'hFFFF_0000, 1'b0},
		'{1'b1, MTC_RTC_SLOPE, 32'h1234_5678, 32'h0000_0000, 1'b0},
		'{1'b0, MTC_RTC_SLOPE, 32'h0000_0000, 32'h1234_5678, 1'b0},
		'{1'b1, MTC_ADC_COEF,  32'h8000_7FFF, 32'h0000_0000, 1'b0},
		'{1'b0, MTC_ADC_COEF,  32'h0000_0000, 32'h8001_7FFF, 1'b0},
		'{1'b1, MTC_IRMS_A,    32'h0000_0055, 32'h0000_0000, 1'b1},
		'{1'b1, MTC_RES_N,     32'h0000_0055, 32'h0000_0000, 1'b1}
	};

	logic        clk;           // 100 MHz clock
	logic        nrst;          // Async reset, active low
	logic        cmd_valid;     // Command strobe from host model
	mtc_cmd_s    cmd;           // Command from host model
	logic        rsp_valid;     // Answer strobe
	logic [31:0] rsp_data;      // Answer data
	logic        cmd_ignored;   // Discard flag
	logic        auto_coef_select;
	logic        post_bypass;
	logic [15:0] auto_linear_coef;
	logic [15:0] auto_quadratic_coef;
	logic        interval_end;  // Interval boundary pulse
	mtc_res_s    res;           // Engine results
	logic        sample_valid;  // Neutral sample strobe
	logic [15:0] sample_a;
	logic [15:0] sample_b;
	logic [15:0] sample_c;
	logic [3:0]  pulses;        // Real, reactive, third, fourth
	logic [31:0] adc_temp_coefficients;
	logic [31:0] rtc_constant_trim_reg;
	logic [31:0] rtc_slope_trim_reg;
	int          bad_count;     // Mismatches
	int          checks;        // Comparisons

	mtc_host_model i_host (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .cmd_ignored(cmd_ignored));

	mtc_regbank i_dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_ignored(cmd_ignored),
		.auto_coef_select(auto_coef_select), .post_bypass(post_bypass),
		.auto_linear_coef(auto_linear_coef), .auto_quadratic_coef(auto_quadratic_coef),
		.interval_end(interval_end), .res(res), .sample_valid(sample_valid),
		.sample_a(sample_a), .sample_b(sample_b), .sample_c(sample_c),
		.real_energy_pulse(pulses[3]), .reactive_energy_pulse(pulses[2]),
		.third_pulse_output(pulses[1]), .fourth_pulse_output(pulses[0]),
		.adc_temp_coefficients(adc_temp_coefficients),
		.rtc_constant_trim_reg(rtc_constant_trim_reg), .rtc_slope_trim_reg(rtc_slope_trim_reg));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic complete_run;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compare one value and report a mismatch at once
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One command with its answer, strobe and discard flag checked
	task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
		input logic [31:0] eq, input logic eig);
		logic [31:0] q;
		logic        ig;
		logic        ok;
		i_host.access(w, a, d, q, ig, ok);
		check("rsp_valid", {31'h0000_0000, ok}, 32'h0000_0001);
		check("rsp_data", q, eq);
		check("cmd_ignored", {31'h0000_0000, ig}, {31'h0000_0000, eig});
	endtask

	// Close one accumulation interval with the given results
	task automatic end_interval(input mtc_res_s rr);
		@(posedge clk);
		interval_end <= 1'b1;
		res          <= rr;
		@(posedge clk);
		interval_end <= 1'b0;
	endtask

	// Hang guard, far beyond the 164 cycles the run needs
	initial begin
		#100us;
		bad_count++;
		complete_run();
	end

	// Main sequence
	initial begin
		mtc_res_s    r;
		logic [31:0] q;
		logic        ig;
		logic        ok;
		longint      t;
		logic [15:0] exp_off;
		bad_count = 0;
		checks = 0;
		nrst = 1'b0;
		{auto_coef_select, post_bypass, interval_end, sample_valid, pulses} = '0;
		{auto_linear_coef, auto_quadratic_coef, sample_a, sample_b, sample_c} = '0;
		res = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		// Plain register cases
		for (int i = 0; i < 14; i++) begin
			xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d, ROWS[i].q, ROWS[i].ig);
		end
		check("rtc_const_port", rtc_constant_trim_reg, 32'hFFFF_0000);
		check("rtc_slope_port", rtc_slope_trim_reg, 32'h1234_5678);
		// Automatic coefficients, refused write, then corrected write-back
		auto_coef_select <= 1'b1;
		auto_linear_coef <= 16'h0123;
		auto_quadratic_coef <= 16'hFF00;
		repeat (4) @(posedge clk);
		xfer(1'b0, MTC_ADC_COEF, 32'h0000_0000, 32'h0123_FF00, 1'b0);
		xfer(1'b1, MTC_ADC_COEF, 32'h5555_5555, 32'h0000_0000, 1'b1);
		auto_coef_select <= 1'b0;
		xfer(1'b1, MTC_ADC_COEF, 32'h0124_FF01, 32'h0000_0000, 1'b0);
		xfer(1'b0, MTC_ADC_COEF, 32'h0000_0000, 32'h0124_FF01, 1'b0);
		check("adc_port", adc_temp_coefficients, 32'h0124_FF01);
		// Zero reference forces both coefficients to zero
		xfer(1'b1, MTC_REF_T, 32'h0000_0000, 32'h0000_0000, 1'b0);
		xfer(1'b0, MTC_ADC_COEF, 32'h0000_0000, 32'h0000_0000, 1'b0);
		xfer(1'b1, MTC_REF_T, 32'h000D_0426, 32'h0000_0000, 1'b0);
		// First interval sets the previous residuals
		r = '{sq_a: 32'h1111_1111, sq_b: 32'h2222_2222, sq_c: 32'h3333_3333,
			res_a: 10'h064, res_b: 10'h005, res_c: 10'h000,
			irms_a: 32'hABCD_1234, irms_b: 32'h1357_9BDF, irms_c: 32'hFFFF_FFFF,
			ang_a: 9'h1FF, ang_b: 9'h005, ang_c: 9'h0FF, freq: 16'h0258, sensor: 32'h000C_E442};
		end_interval(r);
		r.res_a = 10'h01E;
		r.res_b = 10'h12C;
		// Pulses and neutral samples, kept off the boundary cycles
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			pulses <= {i < 3, i < 2, i < 1, 1'b1};
			sample_valid <= (i < 3);
			sample_a <= (i < 2) ? 16'h000A : 16'h0001;
			sample_b <= (i < 2) ? 16'h0014 : 16'h0001;
			sample_c <= (i < 2) ? 16'h0002 : 16'h0001;
			@(posedge clk);
			pulses <= 4'h0;
			sample_valid <= 1'b0;
		end
		end_interval(r);
		t = -(longint'(22721) * (longint'(844866) - longint'(853030)));
		exp_off = 16'(t >>> 22);
		xfer(1'b0, MTC_PULSE_EN, 32'h0000_0000, 32'h0003_0002, 1'b0);
		xfer(1'b0, MTC_PULSE_AUX, 32'h0000_0000, 32'h0001_0004, 1'b0);
		xfer(1'b0, MTC_SQ_A, 32'h0000_0000, 32'h1111_1111, 1'b0);
		xfer(1'b0, MTC_SQ_C, 32'h0000_0000, 32'h3333_3333, 1'b0);
		xfer(1'b0, MTC_RES_A, 32'h0000_0000, 32'hFFFF_FFBA, 1'b0);
		xfer(1'b0, MTC_RES_B, 32'h0000_0000, 32'h0000_0127, 1'b0);
		xfer(1'b0, MTC_SQ_N, 32'h0000_0000, 32'h0000_0002, 1'b0);
		xfer(1'b0, MTC_RES_N, 32'h0000_0000, 32'h0000_0009, 1'b0);
		xfer(1'b0, MTC_IRMS_A, 32'h0000_0000, 32'hABCD_0000, 1'b0);
		xfer(1'b0, MTC_ANGLES, 32'h0000_0000, {5'h00, 9'h1FF, 9'h005, 9'h0FF}, 1'b0);
		xfer(1'b0, MTC_FREQ_TEMP, 32'h0000_0000, {16'h0258, exp_off}, 1'b0);
		// Bypassed interval, one real pulse on its closing boundary
		post_bypass <= 1'b1;
		@(posedge clk);
		interval_end <= 1'b1;
		pulses <= 4'h8;
		@(posedge clk);
		interval_end <= 1'b0;
		pulses <= 4'h0;
		xfer(1'b0, MTC_IRMS_C, 32'h0000_0000, 32'h0000_0000, 1'b0);
		xfer(1'b0, MTC_ANGLES, 32'h0000_0000, 32'h0000_0000, 1'b0);
		xfer(1'b0, MTC_PULSE_EN, 32'h0000_0000, 32'h0001_0000, 1'b0);
		xfer(1'b0, MTC_RES_N, 32'h0000_0000, 32'hFFFF_FFF7, 1'b0);
		// Calibration copy of the sensor reading into the reference
		post_bypass <= 1'b0;
		i_host.access(1'b0, MTC_SENSOR_T, 32'h0000_0000, q, ig, ok);
		check("sensor", q, 32'h000C_E442);
		xfer(1'b1, MTC_REF_T, q, 32'h0000_0000, 1'b0);
		end_interval(r);
		xfer(1'b0, MTC_FREQ_TEMP, 32'h0000_0000, 32'h0258_0000, 1'b0);
		// Boundary pulse must not reappear in the following interval
		xfer(1'b0, MTC_PULSE_EN, 32'h0000_0000, 32'h0000_0000, 1'b0);
		// Mid-run reset restores the scale factor and clears results
		xfer(1'b1, MTC_SCALE, 32'h0000_1111, 32'h0000_0000, 1'b0);
		xfer(1'b0, MTC_SCALE, 32'h0000_0000, 32'h0000_1111, 1'b0);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		xfer(1'b0, MTC_SCALE, 32'h0000_0000, 32'h0000_58C1, 1'b0);
		xfer(1'b0, MTC_SQ_A, 32'h0000_0000, 32'h0000_0000, 1'b0);
		complete_run();
	end
endmodule

// ==== rtl/mtc_pkg.sv ====
// Shared constants and carriers for the temperature and result register bank
package mtc_pkg;
	// Register indices as seen on the command port
	localparam logic [6:0] MTC_IRMS_A     = 7'h0C;  // Phase A RMS current
	localparam logic [6:0] MTC_IRMS_B     = 7'h0D;  // Phase B RMS current
	localparam logic [6:0] MTC_IRMS_C     = 7'h0E;  // Phase C RMS current
	localparam logic [6:0] MTC_ANGLES     = 7'h0F;  // Packed current phase angles
	localparam logic [6:0] MTC_FREQ_TEMP  = 7'h11;  // Line frequency and temp offset
	localparam logic [6:0] MTC_SENSOR_T   = 7'h12;  // Raw sensor temperature
	localparam logic [6:0] MTC_REF_T      = 7'h13;  // Reference temperature
	localparam logic [6:0] MTC_RTC_CONST  = 7'h18;  // RTC constant trim
	localparam logic [6:0] MTC_RTC_SLOPE  = 7'h19;  // RTC linear and quadratic trim
	localparam logic [6:0] MTC_ADC_COEF   = 7'h1B;  // ADC linear and quadratic coefs
	localparam logic [6:0] MTC_SCALE      = 7'h1C;  // Temperature scale factor
	localparam logic [6:0] MTC_SQ_A       = 7'h39;  // Phase A square sum
	localparam logic [6:0] MTC_SQ_B       = 7'h3A;  // Phase B square sum
	localparam logic [6:0] MTC_SQ_C       = 7'h3B;  // Phase C square sum
	localparam logic [6:0] MTC_SQ_N       = 7'h3C;  // Neutral square sum
	localparam logic [6:0] MTC_PULSE_EN   = 7'h41;  // Real and reactive pulse counts
	localparam logic [6:0] MTC_PULSE_AUX  = 7'h42;  // Third and fourth pulse counts
	localparam logic [6:0] MTC_RES_A      = 7'h4A;  // Phase A square residual
	localparam logic [6:0] MTC_RES_B      = 7'h4B;  // Phase B square residual
	localparam logic [6:0] MTC_RES_C      = 7'h4C;  // Phase C square residual
	localparam logic [6:0] MTC_RES_N      = 7'h4D;  // Neutral square residual

	// Reset values
	localparam logic [31:0] MTC_SCALE_RST = 32'h0000_58C1;  // Scale factor 22721
	localparam logic [31:0] MTC_ZERO_RST  = 32'h0000_0000;  // All other registers

	// Field positions and widths
	localparam int          MTC_HI_LSB    = 16;     // Upper half-word position
	localparam int          MTC_HALF_W    = 16;     // Half-word width
	localparam int          MTC_ANG_W     = 9;      // One angle field width
	localparam int          MTC_ANG_C_LSB = 0;      // Phase C angle position
	localparam int          MTC_ANG_B_LSB = 9;      // Phase B angle position
	localparam int          MTC_ANG_A_LSB = 18;     // Phase A angle position
	localparam int          MTC_RES_W     = 10;     // Residual width
	localparam int          MTC_TEMP_SHR  = 22;     // Offset scaling shift
	localparam logic [15:0] MTC_COEF_MIN  = 16'h8001;  // Most negative legal coef
	localparam logic [15:0] MTC_COEF_BAD  = 16'h8000;  // Out-of-range coef code

	// One host command
	typedef struct packed {
		logic        write;  // 1 write, 0 read
		logic [6:0]  addr;   // Register index
		logic [31:0] wdata;  // Write data
	} mtc_cmd_s;

	// Per-interval results from the compute engine and post-processor
	typedef struct packed {
		logic [31:0] sq_a;     // Phase A square sum
		logic [31:0] sq_b;     // Phase B square sum
		logic [31:0] sq_c;     // Phase C square sum
		logic [9:0]  res_a;    // Phase A square residual of this interval
		logic [9:0]  res_b;    // Phase B square residual
		logic [9:0]  res_c;    // Phase C square residual
		logic [31:0] irms_a;   // Phase A RMS current, upper 16 bits meaningful
		logic [31:0] irms_b;   // Phase B RMS current
		logic [31:0] irms_c;   // Phase C RMS current
		logic [8:0]  ang_a;    // Phase A angle, signed degrees
		logic [8:0]  ang_b;    // Phase B angle
		logic [8:0]  ang_c;    // Phase C angle
		logic [15:0] freq;     // Line frequency
		logic [31:0] sensor;   // Raw sensor temperature
	} mtc_res_s;
endpackage

// ==== rtl/mtc_regbank.sv ====
// Temperature compensation and measurement result register bank
module mtc_regbank
	import mtc_pkg::*;
#(
	parameter int ACC_W = 48  // Neutral accumulator width
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        cmd_valid,
	input  wire mtc_cmd_s    cmd,
	output logic             rsp_valid,
	output logic [31:0]      rsp_data,
	output logic             cmd_ignored,
	input  wire logic        auto_coef_select,
	input  wire logic        post_bypass,
	input  wire logic [15:0] auto_linear_coef,
	input  wire logic [15:0] auto_quadratic_coef,
	input  wire logic        interval_end,
	input  wire mtc_res_s    res,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample_a,
	input  wire logic [15:0] sample_b,
	input  wire logic [15:0] sample_c,
	input  wire logic        real_energy_pulse,
	input  wire logic        reactive_energy_pulse,
	input  wire logic        third_pulse_output,
	input  wire logic        fourth_pulse_output,
	output logic [31:0]      adc_temp_coefficients,
	output logic [31:0]      rtc_constant_trim_reg,
	output logic [31:0]      rtc_slope_trim_reg
);

	// Clamp a coefficient into the symmetric signed range
	function automatic logic [15:0] clamp_coef(input logic [15:0] v);
		clamp_coef = (v == MTC_COEF_BAD) ? MTC_COEF_MIN : v;
	endfunction

	// Signed difference of two residuals, sign-extended to a word
	function automatic logic [31:0] res_diff(input logic [9:0] cur, input logic [9:0] prv);
		logic [10:0] d;
		d = {1'b0, cur} - {1'b0, prv};
		res_diff = {{21{d[10]}}, d};
	endfunction

	// Host-writable registers
	logic [31:0] ref_temp_r;       // Reference temperature
	logic [31:0] scale_r;          // Temperature scale factor
	logic [31:0] adc_coef_r;       // ADC coefficients
	logic [31:0] rtc_const_r;      // RTC constant trim
	logic [31:0] rtc_slope_r;      // RTC slope trims
	// Result registers, refreshed at interval end
	logic [31:0] irms_a_r;         // Phase A RMS current
	logic [31:0] irms_b_r;         // Phase B RMS current
	logic [31:0] irms_c_r;         // Phase C RMS current
	logic [31:0] angles_r;         // Packed angles
	logic [31:0] freq_temp_r;      // Frequency and temp offset
	logic [31:0] sensor_r;         // Raw sensor temperature
	logic [31:0] sq_a_r;           // Phase A square sum
	logic [31:0] sq_b_r;           // Phase B square sum
	logic [31:0] sq_c_r;           // Phase C square sum
	logic [31:0] sq_n_r;           // Neutral square sum
	logic [31:0] pulse_en_r;       // Real and reactive counts
	logic [31:0] pulse_aux_r;      // Third and fourth counts
	logic [31:0] res_a_r;          // Phase A residual difference
	logic [31:0] res_b_r;          // Phase B residual difference
	logic [31:0] res_c_r;          // Phase C residual difference
	logic [31:0] res_n_r;          // Neutral residual difference
	// Working state
	logic [9:0]  prev_a_r;         // Previous phase A residual
	logic [9:0]  prev_b_r;         // Previous phase B residual
	logic [9:0]  prev_c_r;         // Previous phase C residual
	logic [9:0]  prev_n_r;         // Previous neutral residual
	logic [ACC_W-1:0] n_acc_r;     // Running neutral accumulator
	logic [15:0] cnt_real_r;       // Running real pulse count
	logic [15:0] cnt_react_r;      // Running reactive pulse count
	logic [15:0] cnt_third_r;      // Running third pulse count
	logic [15:0] cnt_fourth_r;     // Running fourth pulse count
	// Response flops
	logic        rsp_valid_r;      // Answer strobe
	logic [31:0] rsp_data_r;       // Answer data
	logic        ignored_r;        // Last command discarded
	// Combinational terms
	logic        wr;               // Write command this cycle
	logic        known;            // Index is mapped
	logic        writable;         // Index accepts writes now
	logic        accept_wr;        // Write takes effect
	logic        ignore;           // Command is discarded
	logic [31:0] rd_mux;           // Read data
	logic signed [32:0] t_diff;    // Raw minus reference
	logic signed [65:0] t_prod;    // Scaled negated difference
	logic [15:0] t_off;            // Temperature offset
	logic signed [17:0] n_sum;     // Sum of the phase samples
	logic [35:0] n_sq;             // Its square
	logic [ACC_W-1:0] n_tot;       // Accumulator with this sample

	// Command decode
	always_comb begin
		wr = cmd_valid & cmd.write;
		known = 1'b1;
		writable = 1'b0;
		unique case (cmd.addr)
			MTC_REF_T, MTC_RTC_CONST, MTC_RTC_SLOPE, MTC_SCALE: begin
				writable = 1'b1;
			end
			MTC_ADC_COEF: begin
				writable = ~auto_coef_select;
			end
			MTC_IRMS_A, MTC_IRMS_B, MTC_IRMS_C, MTC_ANGLES, MTC_FREQ_TEMP,
			MTC_SENSOR_T, MTC_SQ_A, MTC_SQ_B, MTC_SQ_C, MTC_SQ_N,
			MTC_PULSE_EN, MTC_PULSE_AUX, MTC_RES_A, MTC_RES_B, MTC_RES_C,
			MTC_RES_N: begin
				writable = 1'b0;
			end
			default: begin
				known = 1'b0;
			end
		endcase
		accept_wr = wr & writable;
		ignore = cmd_valid & (~known | (cmd.write & ~writable));
	end

	// Read data selection
	always_comb begin
		unique case (cmd.addr)
			MTC_IRMS_A:    rd_mux = irms_a_r;
			MTC_IRMS_B:    rd_mux = irms_b_r;
			MTC_IRMS_C:    rd_mux = irms_c_r;
			MTC_ANGLES:    rd_mux = angles_r;
			MTC_FREQ_TEMP: rd_mux = freq_temp_r;
			MTC_SENSOR_T:  rd_mux = sensor_r;
			MTC_REF_T:     rd_mux = ref_temp_r;
			MTC_RTC_CONST: rd_mux = rtc_const_r;
			MTC_RTC_SLOPE: rd_mux = rtc_slope_r;
			MTC_ADC_COEF:  rd_mux = adc_coef_r;
			MTC_SCALE:     rd_mux = scale_r;
			MTC_SQ_A:      rd_mux = sq_a_r;
			MTC_SQ_B:      rd_mux = sq_b_r;
			MTC_SQ_C:      rd_mux = sq_c_r;
			MTC_SQ_N:      rd_mux = sq_n_r;
			MTC_PULSE_EN:  rd_mux = pulse_en_r;
			MTC_PULSE_AUX: rd_mux = pulse_aux_r;
			MTC_RES_A:     rd_mux = res_a_r;
			MTC_RES_B:     rd_mux = res_b_r;
			MTC_RES_C:     rd_mux = res_c_r;
			MTC_RES_N:     rd_mux = res_n_r;
			default:       rd_mux = MTC_ZERO_RST;  // Unmapped reads as zero
		endcase
	end

	// Answer every command one cycle later; writes answer with zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= MTC_ZERO_RST;
			ignored_r   <= 1'b0;
		end else begin
			rsp_valid_r <= cmd_valid;
			rsp_data_r  <= (cmd_valid & ~cmd.write) ? rd_mux : MTC_ZERO_RST;
			if (cmd_valid) begin
				ignored_r <= ignore;
			end
		end
	end

	// Host configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_temp_r  <= MTC_ZERO_RST;
			scale_r     <= MTC_SCALE_RST;
			rtc_const_r <= MTC_ZERO_RST;
			rtc_slope_r <= MTC_ZERO_RST;
		end else if (accept_wr) begin
			unique case (cmd.addr)
				MTC_REF_T: begin
					ref_temp_r <= cmd.wdata;
				end
				MTC_SCALE: begin
					scale_r <= cmd.wdata;
				end
				MTC_RTC_CONST: begin
					// Only the upper half carries the trim
					rtc_const_r <= {cmd.wdata[31:16], 16'h0000};
				end
				MTC_RTC_SLOPE: begin
					rtc_slope_r <= cmd.wdata;
				end
				default: begin
					ref_temp_r <= ref_temp_r;
				end
			endcase
		end
	end

	// ADC coefficients: auto load, host write, zero without reference
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adc_coef_r <= MTC_ZERO_RST;
		end else if (ref_temp_r == MTC_ZERO_RST) begin
			adc_coef_r <= MTC_ZERO_RST;
		end else if (auto_coef_select) begin
			// Device-derived values, readable by the host for correction
			adc_coef_r <= {clamp_coef(auto_linear_coef),
				clamp_coef(auto_quadratic_coef)};
		end else if (accept_wr && cmd.addr == MTC_ADC_COEF) begin
			adc_coef_r <= {clamp_coef(cmd.wdata[31:16]),
				clamp_coef(cmd.wdata[15:0])};
		end
	end

	// Temperature offset in tenths of a degree
	always_comb begin
		// Reading latched with the offset, so both registers agree after the update
		t_diff = $signed({res.sensor[31], res.sensor}) - $signed({ref_temp_r[31], ref_temp_r});
		t_prod = -($signed({{2{scale_r[31]}}, scale_r}) * t_diff);
		t_off  = t_prod[MTC_TEMP_SHR +: MTC_HALF_W];
	end

	// Neutral current: square of the summed phase samples
	always_comb begin
		n_sum = $signed({{2{sample_a[15]}}, sample_a})
			+ $signed({{2{sample_b[15]}}, sample_b})
			+ $signed({{2{sample_c[15]}}, sample_c});
		n_sq  = 36'(n_sum) * 36'(n_sum);
		n_tot = n_acc_r + (sample_valid ? ACC_W'(n_sq) : ACC_W'(0));
	end

	// Neutral accumulator restarts each interval
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			n_acc_r <= '0;
		end else if (interval_end) begin
			n_acc_r <= '0;
		end else begin
			n_acc_r <= n_tot;
		end
	end

	// Running pulse counters; each generator carries its own residue in time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_real_r   <= 16'h0000;
			cnt_react_r  <= 16'h0000;
			cnt_third_r  <= 16'h0000;
			cnt_fourth_r <= 16'h0000;
		end else if (interval_end) begin
			// A boundary pulse counts once, in the closing snapshot only
			cnt_real_r   <= 16'h0000;
			cnt_react_r  <= 16'h0000;
			cnt_third_r  <= 16'h0000;
			cnt_fourth_r <= 16'h0000;
		end else begin
			cnt_real_r   <= cnt_real_r + {15'h0000, real_energy_pulse};
			cnt_react_r  <= cnt_react_r + {15'h0000, reactive_energy_pulse};
			cnt_third_r  <= cnt_third_r + {15'h0000, third_pulse_output};
			cnt_fourth_r <= cnt_fourth_r + {15'h0000, fourth_pulse_output};
		end
	end

	// Result snapshot: all results move together at interval end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irms_a_r    <= MTC_ZERO_RST;
			irms_b_r    <= MTC_ZERO_RST;
			irms_c_r    <= MTC_ZERO_RST;
			angles_r    <= MTC_ZERO_RST;
			freq_temp_r <= MTC_ZERO_RST;
			sensor_r    <= MTC_ZERO_RST;
			sq_a_r      <= MTC_ZERO_RST;
			sq_b_r      <= MTC_ZERO_RST;
			sq_c_r      <= MTC_ZERO_RST;
			sq_n_r      <= MTC_ZERO_RST;
			pulse_en_r  <= MTC_ZERO_RST;
			pulse_aux_r <= MTC_ZERO_RST;
		end else if (interval_end) begin
			if (post_bypass) begin
				irms_a_r <= MTC_ZERO_RST;
				irms_b_r <= MTC_ZERO_RST;
				irms_c_r <= MTC_ZERO_RST;
				angles_r <= MTC_ZERO_RST;
			end else begin
				irms_a_r <= {res.irms_a[31:16], 16'h0000};
				irms_b_r <= {res.irms_b[31:16], 16'h0000};
				irms_c_r <= {res.irms_c[31:16], 16'h0000};
				angles_r <= {5'h00, res.ang_a, res.ang_b, res.ang_c};
			end
			freq_temp_r <= {res.freq, t_off};
			sensor_r    <= res.sensor;
			sq_a_r      <= res.sq_a;
			sq_b_r      <= res.sq_b;
			sq_c_r      <= res.sq_c;
			sq_n_r      <= n_tot[MTC_RES_W +: 32];
			pulse_en_r  <= {cnt_real_r + {15'h0000, real_energy_pulse},
				cnt_react_r + {15'h0000, reactive_energy_pulse}};
			pulse_aux_r <= {cnt_third_r + {15'h0000, third_pulse_output},
				cnt_fourth_r + {15'h0000, fourth_pulse_output}};
		end
	end

	// Residual differences against the previous interval
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_a_r <= 10'h000;
			prev_b_r <= 10'h000;
			prev_c_r <= 10'h000;
			prev_n_r <= 10'h000;
			res_a_r  <= MTC_ZERO_RST;
			res_b_r  <= MTC_ZERO_RST;
			res_c_r  <= MTC_ZERO_RST;
			res_n_r  <= MTC_ZERO_RST;
		end else if (interval_end) begin
			prev_a_r <= res.res_a;
			prev_b_r <= res.res_b;
			prev_c_r <= res.res_c;
			prev_n_r <= n_tot[MTC_RES_W-1:0];
			res_a_r  <= res_diff(res.res_a, prev_a_r);
			res_b_r  <= res_diff(res.res_b, prev_b_r);
			res_c_r  <= res_diff(res.res_c, prev_c_r);
			res_n_r  <= res_diff(n_tot[MTC_RES_W-1:0], prev_n_r);
		end
	end

	// Outputs straight from flops
	assign rsp_valid             = rsp_valid_r;
	assign rsp_data              = rsp_data_r;
	assign cmd_ignored           = ignored_r;
	assign adc_temp_coefficients = adc_coef_r;
	assign rtc_constant_trim_reg = rtc_const_r;
	assign rtc_slope_trim_reg    = rtc_slope_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	ref_zero_coef_a: assert property ((ref_temp_r == MTC_ZERO_RST) && !accept_wr
		|=> adc_coef_r == MTC_ZERO_RST) else $error("coefs not zero with zero reference");
	coef_range_a: assert property (adc_coef_r[31:16] != MTC_COEF_BAD
		&& adc_coef_r[15:0] != MTC_COEF_BAD) else $error("coef outside range");
	ro_write_flag_a: assert property (cmd_valid && cmd.write
		&& cmd.addr == MTC_SENSOR_T |=> cmd_ignored && rsp_valid)
		else $error("read-only write not flagged");
	ro_write_hold_a: assert property (cmd_valid && cmd.write
		&& cmd.addr == MTC_SENSOR_T && !interval_end |=> $stable(sensor_r))
		else $error("raw temperature changed by write");
	auto_write_a: assert property (cmd_valid && cmd.write && auto_coef_select
		&& cmd.addr == MTC_ADC_COEF |=> cmd_ignored) else $error("auto coef write accepted");
	bypass_zero_a: assert property (interval_end && post_bypass
		|=> irms_a_r == MTC_ZERO_RST && angles_r == MTC_ZERO_RST)
		else $error("results produced in bypass");
	pulse_restart_a: assert property (interval_end
		|=> cnt_real_r == 16'h0000 && cnt_fourth_r == 16'h0000)
		else $error("pulse counter not restarted");
	pulse_pack_a: assert property (interval_end && !real_energy_pulse && !reactive_energy_pulse
		|=> pulse_en_r == {$past(cnt_real_r), $past(cnt_react_r)})
		else $error("energy pulse counts misplaced");
	temp_offset_a: assert property (interval_end
		|=> freq_temp_r[15:0] == $past(t_off) && freq_temp_r[31:16] == $past(res.freq))
		else $error("temperature offset misplaced");
	residual_a: assert property (interval_end
		|=> res_a_r == res_diff($past(res.res_a), $past(prev_a_r)))
		else $error("residual difference wrong");
	scale_reset_a: assert property ($rose(nrst) |-> scale_r == MTC_SCALE_RST)
		else $error("scale factor reset wrong");

endmodule
